// ==== include/bbr_pkg.sv ====
// Package for the bit-band alias remapper: address map, sizes, bus carriers, state.
// Assumes a 32-bit little-endian data bus with byte lanes selected by address bits 1:0.
package bbr_pkg;

	// Alias windows are 32 MB, selected by address bits 31:25
	localparam int          TAG_MSB        = 31;
	localparam int          TAG_LSB        = 25;
	localparam logic [6:0]  SRAM_ALIAS_TAG = 7'h11;
	localparam logic [6:0]  PERI_ALIAS_TAG = 7'h21;
	localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
	localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
	localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
	localparam logic [31:0] PERI_BAND_BASE = 32'h4000_0000;
	// Alias address fields: byte offset in 24:5, bit number in 4:2
	localparam int          BYTE_OFS_MSB   = 24;
	localparam int          BYTE_OFS_LSB   = 5;
	localparam int          BIT_NUM_MSB    = 4;
	localparam int          BIT_NUM_LSB    = 2;

	// Access sizes
	localparam logic [1:0]  SIZE_BYTE      = 2'h0;
	localparam logic [1:0]  SIZE_HALF      = 2'h1;
	localparam logic [1:0]  SIZE_WORD      = 2'h2;

	localparam logic [31:0] ALIAS_CLEAR    = 32'h0000_0000;
	localparam logic [31:0] ALIAS_SET      = 32'h0000_0001;
	localparam logic [1:0]  RESET_SYNC     = 2'h0;

	typedef struct packed {
		logic        instr;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bbr_req_t;

	typedef struct packed {
		logic        err;
		logic [31:0] data;
	} bbr_rsp_t;

	typedef struct packed {
		logic        write;
		logic        lock;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bbr_mreq_t;

	typedef struct packed {
		logic        remap;
		logic        sram;
		logic        refuse;
		logic [31:0] target;
		logic [4:0]  bitIdx;
	} bbr_dec_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ISSUE,
		PH_WAIT,
		PH_RESP
	} bbr_phase_t;

	typedef struct packed {
		bbr_phase_t  phase;
		logic        remap;
		logic        origWrite;
		logic        wrPhase;
		logic        wbit;
		logic [4:0]  bitIdx;
		bbr_mreq_t   mem;
		bbr_rsp_t    rsp;
	} bbr_state_t;

	localparam bbr_state_t STATE_RESET = '{
		phase: PH_IDLE, remap: 1'b0, origWrite: 1'b0, wrPhase: 1'b0, wbit: 1'b0,
		bitIdx: 5'h00, mem: '0, rsp: '0};

endpackage

// ==== logic/bbr_alias_decode.sv ====
// Alias address decoder: classifies an upstream address and finds the target bit.
// Purely combinational; the remapper registers what it takes from here, except dec.sram, which only its checks read.
`timescale 1ns/1ps
`default_nettype none
module bbr_alias_decode (
	// Upstream access
	input  wire logic [31:0]      addr,
	input  wire logic             instr,
	// Decoded result
	output bbr_pkg::bbr_dec_t     dec
);
	import bbr_pkg::*;

	logic sramHit;
	logic periHit;
	logic [31:0] bandBase;

	assign sramHit  = addr[TAG_MSB:TAG_LSB] == SRAM_ALIAS_TAG;
	assign periHit  = addr[TAG_MSB:TAG_LSB] == PERI_ALIAS_TAG;
	assign bandBase = sramHit ? SRAM_BAND_BASE : PERI_BAND_BASE;

	always_comb begin
		// Fetches from the SRAM alias go through untouched; peripheral ones are refused
		dec.remap  = (sramHit || periHit) && !instr;
		dec.sram   = sramHit;
		dec.refuse = periHit && instr;
		// Byte offset is alias offset / 32, bit number is (alias offset / 4) mod 8
		dec.target = bandBase | {12'h000, addr[BYTE_OFS_MSB:BYTE_OFS_LSB]};
		// Bit position within the 32-bit lane, little-endian by byte
		dec.bitIdx = {addr[BYTE_OFS_LSB+1:BYTE_OFS_LSB], addr[BIT_NUM_MSB:BIT_NUM_LSB]};
	end
endmodule
`default_nettype wire

// ==== logic/bbr_remapper.sv ====
// Bit-band alias remapper between the core data bus and SRAM/peripheral slaves.
// Assumes one request at a time upstream and an in-order, one-answer-per-request downstream.
`timescale 1ns/1ps
`default_nettype none
module bbr_remapper (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	// Upstream request from the core
	input  wire logic             reqValid,
	output logic                  reqReady,
	input  wire bbr_pkg::bbr_req_t req,
	// Upstream answer
	output logic                  rspValid,
	output bbr_pkg::bbr_rsp_t     rsp,
	// Downstream request to memory
	output logic                  memValid,
	input  wire logic             memReady,
	output bbr_pkg::bbr_mreq_t    memReq,
	// Downstream answer
	input  wire logic             memRspValid,
	input  wire bbr_pkg::bbr_rsp_t memRsp
);
	import bbr_pkg::*;

	function automatic logic [31:0] alignAddr(input logic [31:0] a, input logic [1:0] sz);
		logic [31:0] r;
		r = a;
		if (sz == SIZE_WORD) begin
			r = {a[31:2], 2'b00};
		end else if (sz == SIZE_HALF) begin
			r = {a[31:1], 1'b0};
		end
		return r;
	endfunction

	logic [1:0]  resetSync;
	logic        rstSyncN;
	bbr_dec_t    dec;
	bbr_state_t  st;
	bbr_state_t  next_st;
	logic        reqFire;

	// Reset released through two flops so every state flop leaves reset together
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			resetSync <= RESET_SYNC;
		end else begin
			resetSync <= {resetSync[0], 1'b1};
		end
	end
	assign rstSyncN = resetSync[1];

	bbr_alias_decode u_decode (
		.addr  (req.addr),
		.instr (req.instr),
		.dec   (dec)
	);

	// One transaction in flight at a time keeps device accesses in order
	assign reqReady = st.phase == PH_IDLE;
	assign reqFire  = reqValid && reqReady;
	assign memValid = st.phase == PH_ISSUE;
	assign memReq   = st.mem;
	assign rspValid = st.phase == PH_RESP;
	assign rsp      = st.rsp;

	always_comb begin
		next_st = st;
		case (st.phase)
			PH_IDLE: begin
				if (reqFire) begin
					next_st.remap     = dec.remap;
					next_st.origWrite = req.write;
					next_st.wrPhase   = 1'b0;
					next_st.wbit      = req.wdata[0];
					next_st.bitIdx    = dec.bitIdx;
					next_st.mem.size  = req.size;
					next_st.mem.lock  = dec.remap && req.write;
					next_st.mem.wdata = req.wdata;
					next_st.rsp       = '0;
					if (dec.refuse) begin
						next_st.rsp.err = 1'b1;
						next_st.phase   = PH_RESP;
					end else if (dec.remap) begin
						// Alias writes start with a read of the underlying word
						next_st.mem.write = 1'b0;
						next_st.mem.addr  = alignAddr(dec.target, req.size);
						next_st.phase     = PH_ISSUE;
					end else begin
						// Band and all other addresses pass unchanged
						next_st.mem.write = req.write;
						next_st.mem.addr  = req.addr;
						next_st.phase     = PH_ISSUE;
					end
				end
			end
			PH_ISSUE: begin
				if (memReady) begin
					next_st.phase = PH_WAIT;
				end
			end
			PH_WAIT: begin
				if (memRspValid) begin
					if (memRsp.err) begin
						next_st.rsp      = memRsp;
						next_st.mem.lock = 1'b0;
						next_st.phase    = PH_RESP;
					end else if (st.remap && st.origWrite && !st.wrPhase) begin
						// Lock stays up, so no other master reaches the word in between
						next_st.mem.wdata = memRsp.data;
						next_st.mem.wdata[st.bitIdx] = st.wbit;
						next_st.mem.write = 1'b1;
						next_st.wrPhase   = 1'b1;
						next_st.phase     = PH_ISSUE;
					end else begin
						if (st.remap) begin
							next_st.rsp.data = memRsp.data[st.bitIdx] ? ALIAS_SET : ALIAS_CLEAR;
						end else begin
							next_st.rsp.data = memRsp.data;
						end
						next_st.rsp.err  = 1'b0;
						next_st.mem.lock = 1'b0;
						next_st.phase    = PH_RESP;
					end
				end
			end
			PH_RESP: begin
				next_st.phase = PH_IDLE;
			end
			default: begin
				next_st = STATE_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Checks
	logic [31:0] aliasTarget;
	assign aliasTarget = alignAddr(dec.target, req.size);

	sequence rmwReadDone_s;
		st.phase == PH_WAIT && memRspValid && !memRsp.err && st.remap && st.origWrite && !st.wrPhase;
	endsequence

	sequence lockedWrite_s;
		memValid && memReq.write && memReq.lock;
	endsequence

	refuse_fetch_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		reqFire && dec.refuse |=> rspValid && rsp.err && !memValid)
		else $error("peripheral alias fetch not refused");

	alias_addr_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		reqFire && dec.remap |=> memValid && !memReq.write && memReq.addr == $past(aliasTarget))
		else $error("alias access did not reach its band word");

	keep_size_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		reqFire && !dec.refuse |=> memValid && memReq.size == $past(req.size))
		else $error("underlying access size differs");

	fetch_pass_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		reqFire && dec.sram && req.instr |=> memReq.addr == $past(req.addr) && !memReq.lock)
		else $error("SRAM alias fetch was remapped");

	rmw_back_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		rmwReadDone_s |=> lockedWrite_s)
		else $error("alias write did not follow its read under lock");

	rmw_bit_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		rmwReadDone_s ##1 lockedWrite_s |->
			memReq.wdata[st.bitIdx] == st.wbit &&
			(memReq.wdata | (32'h1 << st.bitIdx)) == ($past(memRsp.data) | (32'h1 << st.bitIdx)))
		else $error("alias write changed the wrong bits");

	alias_read_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		st.phase == PH_WAIT && memRspValid && !memRsp.err && st.remap && !st.origWrite
		|=> rspValid && rsp.data == {31'h0, $past(memRsp.data[st.bitIdx])})
		else $error("alias read value wrong");

	in_order_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		rspValid |-> !reqReady ##1 (reqReady && !rspValid && !memValid))
		else $error("answer not single or next request taken early");

	// Band and other plain addresses reach memory untouched
	plain_pass_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		reqFire && !dec.remap && !dec.refuse |=> memValid && memReq.addr == $past(req.addr)
			&& memReq.write == $past(req.write) && memReq.wdata == $past(req.wdata))
		else $error("plain access altered on its way to memory");

	// A stalled slave must keep seeing the same request
	req_hold_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		memValid && !memReady |=> memValid && $stable(memReq))
		else $error("memory request changed before it was taken");

	// Lock never outlives its transaction
	lock_drop_a: assert property (@(posedge core_clk) disable iff (!rstSyncN)
		rspValid |-> !memReq.lock)
		else $error("lock still held at the answer");
endmodule
`default_nettype wire

// ==== test/bbr_mem_model.sv ====
// Memory slave model for the remapper's downstream port: word store, byte lanes.
// Assumes one request at a time; answers one cycle after acceptance.
`timescale 1ns/1ps
`default_nettype none
module bbr_mem_model
	import bbr_pkg::*;
(
	// Clock, reset and pacing
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       slow,
	input  wire logic       fail,
	// Request side
	input  wire logic       memValid,
	output logic            memReady,
	input  wire bbr_mreq_t  memReq,
	// Answer side
	output logic            memRspValid,
	output bbr_rsp_t        memRsp
);
	logic [31:0] mem [logic [29:0]];
	logic [1:0]  lastSize;
	logic        lastLock;
	logic [31:0] lastAddr;
	logic [1:0]  cnt;
	logic [31:0] w;
	bit          en;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			memReady <= 1'b0;
			memRspValid <= 1'b0;
			memRsp <= '0;
			cnt <= 2'h0;
		end else begin
			cnt <= cnt + 2'h1;
			// Slow pacing stalls three cycles of four
			memReady <= !slow || cnt == 2'h3;
			memRspValid <= 1'b0;
			// Idle answer lines never keep the last value
			memRsp <= ~memRsp;
			if (memValid && memReady) begin
				memReady <= 1'b0;
				lastSize <= memReq.size;
				lastLock <= memReq.lock;
				lastAddr <= memReq.addr;
				w = mem.exists(memReq.addr[31:2]) ? mem[memReq.addr[31:2]] : 32'h0;
				// Error answers leave the store untouched
				if (memReq.write && !fail) begin
					for (int i = 0; i < 4; i++) begin
						en = memReq.size == SIZE_WORD || (memReq.size == SIZE_HALF
							&& i[1] == memReq.addr[1]) || i[1:0] == memReq.addr[1:0];
						if (en)
							w[8*i +: 8] = memReq.wdata[8*i +: 8];
					end
					mem[memReq.addr[31:2]] = w;
				end
				memRspValid <= 1'b1;
				memRsp <= '{err: fail, data: w};
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the bit-band alias remapper.
// Assumes the memory model as the only downstream slave.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bbr_pkg::*;
	logic      core_clk = 0, reset_n = 0, reqValid = 0, slow = 0, fail = 0;
	logic      reqReady, rspValid, memValid, memReady, memRspValid;
	bbr_req_t  req = '0;
	bbr_rsp_t  rsp, memRsp, got;
	bbr_mreq_t memReq;
	int        n_errors = 0, n_compared = 0, cyc = 0;

	always #5 core_clk = ~core_clk;

	bbr_remapper dut_u (.core_clk, .reset_n, .reqValid, .reqReady, .req, .rspValid, .rsp,
		.memValid, .memReady, .memReq, .memRspValid, .memRsp);
	bbr_mem_model p_u (.core_clk, .reset_n, .slow, .fail, .memValid, .memReady, .memReq,
		.memRspValid, .memRsp);

	task results;
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Hang guard, far above the expected run
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			results;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One upstream access; held until taken, answer sampled mid-cycle
	task acc(input logic i, input logic w, input logic [1:0] sz, input logic [31:0] a,
		input logic [31:0] d);
		int k;
		@(posedge core_clk);
		req <= '{instr: i, write: w, size: sz, addr: a, wdata: d};
		reqValid <= 1'b1;
		@(negedge core_clk);
		for (k = 0; k < 50 && reqReady !== 1'b1; k++)
			@(negedge core_clk);
		@(posedge core_clk);
		reqValid <= 1'b0;
		req <= ~req;
		for (k = 0; k < 60 && rspValid !== 1'b1; k++)
			@(negedge core_clk);
		if (k == 60)
			chk(32'h0, 32'h1);
		got = rsp;
	endtask

	function automatic logic [31:0] al(logic [31:0] b, logic [19:0] o, int n);
		return b + {o, 5'h00} + 32'(n * 4);
	endfunction

	task t_read;
		acc(0, 1, SIZE_WORD, 32'h2000_0010, 32'h0000_8100);
		for (int b = 0; b < 8; b++) begin
			acc(0, 0, SIZE_WORD, al(SRAM_ALIAS_BASE, 20'h00011, b), 32'h0);
			chk(got.data, {31'h0, b == 0 || b == 7});
		end
	endtask

	task t_write;
		acc(0, 1, SIZE_WORD, al(SRAM_ALIAS_BASE, 20'h00012, 3), 32'hFFFF_FFF1);
		chk(32'(p_u.lastLock), 32'h1);
		acc(0, 1, SIZE_WORD, al(SRAM_ALIAS_BASE, 20'h00011, 0), 32'h0000_000E);
		chk(p_u.lastAddr, 32'h2000_0010);
		acc(0, 0, SIZE_WORD, 32'h2000_0010, 32'h0);
		chk(got.data, 32'h0008_8000);
		chk(32'(p_u.lastLock), 32'h0);
	endtask

	// Slave error on the read half: error comes back, no write follows
	task t_fault;
		fail <= 1'b1;
		acc(0, 1, SIZE_WORD, al(SRAM_ALIAS_BASE, 20'h00013, 2), 32'h0000_0001);
		chk(32'(got.err), 32'h1);
		fail <= 1'b0;
		acc(0, 0, SIZE_WORD, 32'h2000_0010, 32'h0);
		chk(got.data, 32'h0008_8000);
	endtask

	// Bit 7 of byte 0x11: byte access stays on the byte, wider ones align down
	task t_size;
		logic [1:0]  s [3];
		logic [31:0] e [3];
		s = '{SIZE_BYTE, SIZE_HALF, SIZE_WORD};
		e = '{32'h2000_0011, 32'h2000_0010, 32'h2000_0010};
		for (int n = 0; n < 3; n++) begin
			acc(0, 0, s[n], al(SRAM_ALIAS_BASE, 20'h00011, 7), 32'h0);
			chk(32'(p_u.lastSize), 32'(s[n]));
			chk(p_u.lastAddr, e[n]);
			chk(got.data, ALIAS_SET);
		end
	endtask

	// Top bit of the peripheral band through a stalling slave
	task t_peri;
		slow = 1'b1;
		acc(0, 1, SIZE_WORD, 32'h43FF_FFFC, 32'h0000_0001);
		acc(0, 0, SIZE_WORD, 32'h400F_FFFC, 32'h0);
		chk(got.data, 32'h8000_0000);
		acc(0, 0, SIZE_WORD, 32'h43FF_FFFC, 32'h0);
		chk(got.data, ALIAS_SET);
		slow = 1'b0;
	endtask

	task t_fetch;
		acc(1, 0, SIZE_WORD, PERI_ALIAS_BASE, 32'h0);
		chk(32'(got.err), 32'h1);
		p_u.mem[30'h0880_0001] = 32'hA5A5_0000;
		acc(1, 0, SIZE_WORD, 32'h2200_0004, 32'h0);
		chk(got.data, 32'hA5A5_0000);
		chk(32'(got.err), 32'h0);
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_read;
		t_write;
		t_fault;
		t_size;
		t_peri;
		t_fetch;
		results;
	end
endmodule
`default_nettype wire
